// ---- rtl/pwmf_pkg.sv ----
// Purpose: constants and state types of the pulse-width generator with fault control
// Assumes: one generator, 32-bit register port, all logic on the PWM clock
// Notes: sync mode codes shared by counting-mode and dead-band updates
package pwmf_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ENABLE = 8'h04;
   localparam logic [7:0] REG_LOAD = 8'h08;
   localparam logic [7:0] REG_CMPA = 8'h0C;
   localparam logic [7:0] REG_CMPB = 8'h10;
   localparam logic [7:0] REG_DBRISE = 8'h14;
   localparam logic [7:0] REG_DBFALL = 8'h18;
   localparam logic [7:0] REG_FSENSE = 8'h1C;
   localparam logic [7:0] REG_MINPER = 8'h20;
   localparam logic [7:0] REG_TRIG0 = 8'h24;
   localparam logic [7:0] REG_TRIG1 = 8'h28;
   localparam logic [7:0] REG_FSTAT0 = 8'h2C;
   localparam logic [7:0] REG_FSTAT1 = 8'h30;
   localparam logic [7:0] REG_FISR = 8'h34;
   localparam logic [7:0] REG_SYNC = 8'h38;
   localparam logic [7:0] REG_COUNT = 8'h3C;
   // ---------------------------------------------------------------
   // control field positions
   // ---------------------------------------------------------------
   localparam int CTRL_UPDOWN = 0;
   localparam int CTRL_SYNCUPD = 1;
   localparam int CTRL_DBG_RUN = 2;
   localparam int CTRL_MSYNC_LO = 3;
   localparam int CTRL_DSYNC_LO = 5;
   localparam int CTRL_LATCHED = 7;
   localparam int CTRL_MINPER = 8;
   localparam int CTRL_EXTSRC = 9;
   localparam int CTRL_DBEN = 10;
   localparam logic [10:0] CTRL_RESET = 11'h000;
   localparam logic [3:0] FSENSE_RESET = 4'hF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [11:0] DB_ONE = 12'h001;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PWMF_SYNC_IMM = 2'b00,
      PWMF_SYNC_LOCAL = 2'b01,
      PWMF_SYNC_GLOBAL = 2'b10
   } pwmf_sync_t;
   typedef struct packed {
      logic [4:0] stage1;
      logic [4:0] stage2;
   } pwmf_sync2_t;
   typedef struct packed {
      logic a_prev;
      logic b;
      logic [11:0] cnt;
   } pwmf_db_t;
   typedef struct packed {
      logic [10:0] ctrl;
      logic en;
      logic [15:0] load;
      logic [15:0] cmpa;
      logic [15:0] cmpb;
      logic [11:0] dbr;
      logic [11:0] dbf;
      logic [3:0] sense;
      logic [15:0] minper;
      logic [3:0] trig0;
      logic [7:0] trig1;
      logic [3:0] stat0;
      logic [7:0] stat1;
      logic [3:0] isr;
      logic glob;
      logic pdirty;
      logic mdirty;
      logic ddirty;
      logic [15:0] cnt;
      logic up;
      logic [15:0] aload;
      logic [15:0] acmpa;
      logic [15:0] acmpb;
      logic aupdn;
      logic [11:0] adbr;
      logic [11:0] adbf;
      logic adben;
      logic [15:0] minc;
      logic generator_output_first;
      logic generator_output_second;
      logic [31:0] rdata;
   } pwmf_state_t;
endpackage

// ---- rtl/pwmf_sync2.sv ----
// Purpose: two-flop synchroniser for fault pins and debug halt
// Assumes: inputs asynchronous to clk_i
// Notes: only the second stage is visible
`timescale 1ns/1ns
module pwmf_sync2 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] async_i,
   output logic [4:0] sync_o
);
   pwmf_pkg::pwmf_sync2_t s;
   pwmf_pkg::pwmf_sync2_t next_s;

   always_comb begin
      next_s.stage1 = async_i;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_o = s.stage2;
endmodule

// ---- rtl/pwmf_deadband.sv ----
// Purpose: delays rising and falling edges of the first output for the second
// Assumes: delays in PWM clock ticks, zero means no delay
// Notes: an edge arriving before the previous delay ends restarts the count
`timescale 1ns/1ns
module pwmf_deadband (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic a_i,
   input wire logic [11:0] rise_i,
   input wire logic [11:0] fall_i,
   output logic b_o
);
   pwmf_pkg::pwmf_db_t s;
   pwmf_pkg::pwmf_db_t next_s;

   always_comb begin
      next_s = s;
      next_s.a_prev = a_i;
      if (a_i != s.a_prev) begin
         next_s.cnt = a_i ? rise_i : fall_i;
         if ((a_i ? rise_i : fall_i) == 12'h000) begin
            next_s.b = a_i;
         end
      end else if (s.cnt > pwmf_pkg::DB_ONE) begin
         next_s.cnt = s.cnt - pwmf_pkg::DB_ONE;
      end else if (s.cnt == pwmf_pkg::DB_ONE) begin
         next_s.cnt = 12'h000;
         next_s.b = a_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign b_o = s.b;
endmodule

// ---- rtl/pwmf_generator.sv ----
// Purpose: one pulse-width generator with counter, comparators and fault control
// Assumes: clk_i is the divided PWM clock; dcmp_i comes from logic on clk_i
// Notes: register reads answer one cycle after the read strobe
`timescale 1ns/1ns

// Summary of operation
// - writing one clears fault interrupt bits
// - fault interrupt is OR of configured triggers
// - configuration write leaves generator disabled
// - down mode counts load to zero, reloads
// - up/down mode counts zero to load, back
// - sync update waits for sync event
// - non-sync update needs no sync event
// - pending load and compare values transfer only at counter zero
// - debug pause stops counter at zero
// - debug run keeps counting while halted
// - counting-mode change immediate, local or global
// - dead-band change immediate, local or global
// - latched faults stay set until cleared
// - software clears latched triggers per group
// - minimum fault period holds fault and interrupt
// - legacy uses fault zero, extended uses set
// - disable stops counter advancing
// - enable lets counter advance
// - minimum period counted in PWM clocks
// - per-input fault sense applied before OR
// - dead-band delays second output edges
module pwmf_generator (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic [3:0] external_fault_input_i,
   input wire logic [7:0] dcmp_i,
   input wire logic debug_halt_i,
   output logic generator_output_first_o,
   output logic generator_output_second_o,
   output logic generator_zero_fault_irq_o
);
   pwmf_pkg::pwmf_state_t s;
   pwmf_pkg::pwmf_state_t next_s;
   logic [4:0] pins;
   logic [3:0] asserted;
   logic [3:0] raw0;
   logic [7:0] raw1;
   logic fault_now;
   logic fault_act;
   logic halt;
   logic tick;
   logic at_zero;
   logic db_out;
   logic apply_p;
   logic [15:0] ld_now;
   pwmf_pkg::pwmf_sync_t msync;
   pwmf_pkg::pwmf_sync_t dsync;

   // ---------------------------------------------------------------
   // change is due under the chosen sync mode
   // ---------------------------------------------------------------
   function automatic logic due(input pwmf_pkg::pwmf_sync_t mode, input logic zero,
                                input logic glob);
      due = (mode == pwmf_pkg::PWMF_SYNC_IMM) ||
            (zero && ((mode == pwmf_pkg::PWMF_SYNC_LOCAL) ||
                      ((mode == pwmf_pkg::PWMF_SYNC_GLOBAL) && glob)));
   endfunction

   pwmf_sync2 u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({debug_halt_i, external_fault_input_i}),
      .sync_o(pins)
   );

   pwmf_deadband u_db (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .a_i(s.generator_output_first),
      .rise_i(s.adbr),
      .fall_i(s.adbf),
      .b_o(db_out)
   );

   // ---------------------------------------------------------------
   // fault sources
   // ---------------------------------------------------------------
   assign halt = pins[4];
   assign asserted = ~(pins[3:0] ^ s.sense);
   assign raw0 = s.ctrl[pwmf_pkg::CTRL_EXTSRC] ? (asserted & s.trig0) :
                 {3'h0, asserted[0]};
   assign raw1 = s.ctrl[pwmf_pkg::CTRL_EXTSRC] ? (dcmp_i & s.trig1) : 8'h00;
   assign fault_now = (|s.stat0) || (|s.stat1) || (|raw0) || (|raw1);
   assign fault_act = fault_now || (s.minc != pwmf_pkg::CNT_ZERO);
   assign msync = pwmf_pkg::pwmf_sync_t'(s.ctrl[pwmf_pkg::CTRL_MSYNC_LO +: 2]);
   assign dsync = pwmf_pkg::pwmf_sync_t'(s.ctrl[pwmf_pkg::CTRL_DSYNC_LO +: 2]);

   // ---------------------------------------------------------------
   // counter advance
   // ---------------------------------------------------------------
   assign tick = s.en && !(halt && !s.ctrl[pwmf_pkg::CTRL_DBG_RUN] &&
                 (s.cnt == pwmf_pkg::CNT_ZERO));
   assign at_zero = tick && (s.cnt == pwmf_pkg::CNT_ZERO);
   assign apply_p = s.pdirty && at_zero && (!s.ctrl[pwmf_pkg::CTRL_SYNCUPD] || s.glob);
   assign ld_now = apply_p ? s.load : s.aload;

   always_comb begin
      next_s = s;
      next_s.rdata = 32'h00000000;
      // counting
      if (tick) begin
         if (!s.aupdn) begin
            next_s.cnt = at_zero ? ld_now : s.cnt - pwmf_pkg::CNT_ONE;
         end else if (at_zero) begin
            next_s.cnt = (ld_now == pwmf_pkg::CNT_ZERO) ? pwmf_pkg::CNT_ZERO : pwmf_pkg::CNT_ONE;
            next_s.up = 1'b1;
         end else if (s.up && (s.cnt < s.aload)) begin
            next_s.cnt = s.cnt + pwmf_pkg::CNT_ONE;
         end else begin
            next_s.cnt = s.cnt - pwmf_pkg::CNT_ONE;
            next_s.up = 1'b0;
         end
      end
      // pending values only at zero; mode and dead-band changes when due under the sync mode
      if (apply_p) begin
         next_s.aload = s.load;
         next_s.acmpa = s.cmpa;
         next_s.acmpb = s.cmpb;
         next_s.pdirty = 1'b0;
      end
      if (s.mdirty && due(msync, at_zero, s.glob)) begin
         next_s.aupdn = s.ctrl[pwmf_pkg::CTRL_UPDOWN];
         next_s.up = 1'b1;
         next_s.mdirty = 1'b0;
      end
      if (s.ddirty && due(dsync, at_zero, s.glob)) begin
         next_s.adbr = s.dbr;
         next_s.adbf = s.dbf;
         next_s.adben = s.ctrl[pwmf_pkg::CTRL_DBEN];
         next_s.ddirty = 1'b0;
      end
      if (at_zero) begin
         next_s.glob = 1'b0;
      end
      // register writes
      if (wr_i) begin
         case (addr_i)
            pwmf_pkg::REG_CTRL: begin
               next_s.ctrl = wdata_i[10:0];
               next_s.en = 1'b0;
               next_s.mdirty = 1'b1;
               next_s.ddirty = 1'b1;
            end
            pwmf_pkg::REG_ENABLE: next_s.en = wdata_i[0];
            pwmf_pkg::REG_LOAD: begin
               next_s.load = wdata_i[15:0];
               next_s.pdirty = 1'b1;
            end
            pwmf_pkg::REG_CMPA: begin
               next_s.cmpa = wdata_i[15:0];
               next_s.pdirty = 1'b1;
            end
            pwmf_pkg::REG_CMPB: begin
               next_s.cmpb = wdata_i[15:0];
               next_s.pdirty = 1'b1;
            end
            pwmf_pkg::REG_DBRISE: begin
               next_s.dbr = wdata_i[11:0];
               next_s.ddirty = 1'b1;
            end
            pwmf_pkg::REG_DBFALL: begin
               next_s.dbf = wdata_i[11:0];
               next_s.ddirty = 1'b1;
            end
            pwmf_pkg::REG_FSENSE: next_s.sense = wdata_i[3:0];
            pwmf_pkg::REG_MINPER: next_s.minper = wdata_i[15:0];
            pwmf_pkg::REG_TRIG0: next_s.trig0 = wdata_i[3:0];
            pwmf_pkg::REG_TRIG1: next_s.trig1 = wdata_i[7:0];
            pwmf_pkg::REG_FSTAT0: next_s.stat0 = s.stat0 & ~wdata_i[3:0];
            pwmf_pkg::REG_FSTAT1: next_s.stat1 = s.stat1 & ~wdata_i[7:0];
            pwmf_pkg::REG_FISR: next_s.isr = s.isr & ~wdata_i[3:0];
            pwmf_pkg::REG_SYNC: next_s.glob = s.glob | wdata_i[0];
            default: ;
         endcase
      end
      // fault status, set wins over clear
      if (s.ctrl[pwmf_pkg::CTRL_LATCHED]) begin
         next_s.stat0 = next_s.stat0 | raw0;
         next_s.stat1 = next_s.stat1 | raw1;
      end else begin
         next_s.stat0 = 4'h0;
         next_s.stat1 = 8'h00;
      end
      if (s.ctrl[pwmf_pkg::CTRL_MINPER] && ((|raw0) || (|raw1))) begin
         next_s.minc = s.minper;
      end else if (s.minc != pwmf_pkg::CNT_ZERO) begin
         next_s.minc = s.minc - pwmf_pkg::CNT_ONE;
      end
      if (!s.ctrl[pwmf_pkg::CTRL_MINPER]) begin
         next_s.minc = pwmf_pkg::CNT_ZERO;
      end
      next_s.isr[0] = next_s.isr[0] | fault_act;
      // outputs, forced low under fault
      next_s.generator_output_first = !fault_act && (s.cnt > s.acmpa);
      next_s.generator_output_second = !fault_act && (s.adben ? db_out : (s.cnt > s.acmpb));
      // register reads
      if (rd_i) begin
         case (addr_i)
            pwmf_pkg::REG_CTRL: next_s.rdata = {21'h000000, s.ctrl};
            pwmf_pkg::REG_ENABLE: next_s.rdata = {31'h00000000, s.en};
            pwmf_pkg::REG_LOAD: next_s.rdata = {16'h0000, s.load};
            pwmf_pkg::REG_CMPA: next_s.rdata = {16'h0000, s.cmpa};
            pwmf_pkg::REG_CMPB: next_s.rdata = {16'h0000, s.cmpb};
            pwmf_pkg::REG_DBRISE: next_s.rdata = {20'h00000, s.dbr};
            pwmf_pkg::REG_DBFALL: next_s.rdata = {20'h00000, s.dbf};
            pwmf_pkg::REG_FSENSE: next_s.rdata = {28'h0000000, s.sense};
            pwmf_pkg::REG_MINPER: next_s.rdata = {16'h0000, s.minper};
            pwmf_pkg::REG_TRIG0: next_s.rdata = {28'h0000000, s.trig0};
            pwmf_pkg::REG_TRIG1: next_s.rdata = {24'h000000, s.trig1};
            pwmf_pkg::REG_FSTAT0: next_s.rdata =
               {28'h0000000, s.ctrl[pwmf_pkg::CTRL_LATCHED] ? s.stat0 : raw0};
            pwmf_pkg::REG_FSTAT1: next_s.rdata =
               {24'h000000, s.ctrl[pwmf_pkg::CTRL_LATCHED] ? s.stat1 : raw1};
            pwmf_pkg::REG_FISR: next_s.rdata = {28'h0000000, s.isr};
            pwmf_pkg::REG_SYNC: next_s.rdata = {31'h00000000, s.glob};
            pwmf_pkg::REG_COUNT: next_s.rdata = {16'h0000, s.cnt};
            default: next_s.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.ctrl <= pwmf_pkg::CTRL_RESET;
         s.sense <= pwmf_pkg::FSENSE_RESET;
         s.up <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign rdata_o = s.rdata;
   assign generator_output_first_o = s.generator_output_first;
   assign generator_output_second_o = s.generator_output_second;
   assign generator_zero_fault_irq_o = s.isr[0];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   disabled_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !s.en |=> (s.cnt == $past(s.cnt)))
      else $error("counter moved while disabled");
   enable_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.en && (s.cnt != pwmf_pkg::CNT_ZERO)) |=> (s.cnt != $past(s.cnt)))
      else $error("enabled counter did not advance");
   down_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (at_zero && !s.aupdn) |=> (s.cnt == $past(ld_now)))
      else $error("down counter did not reload");
   updown_turn_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (at_zero && s.aupdn && (ld_now != pwmf_pkg::CNT_ZERO)) |=> (s.cnt == pwmf_pkg::CNT_ONE))
      else $error("up/down counter did not turn up at zero");
   zero_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.acmpa != $past(s.acmpa)) |-> $past(at_zero))
      else $error("comparator changed away from zero");
   sync_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[pwmf_pkg::CTRL_SYNCUPD] && !s.glob) |=> (s.aload == $past(s.aload)))
      else $error("sync update applied without sync event");
   config_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_i && (addr_i == pwmf_pkg::REG_CTRL)) |=> !s.en)
      else $error("generator enabled after configuration write");
   isr_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_i && (addr_i == pwmf_pkg::REG_FISR) && wdata_i[0] && !fault_act) |=> !s.isr[0])
      else $error("fault interrupt not cleared");
   debug_pause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (halt && !s.ctrl[pwmf_pkg::CTRL_DBG_RUN] && (s.cnt == pwmf_pkg::CNT_ZERO))
      |=> (s.cnt == pwmf_pkg::CNT_ZERO))
      else $error("counter left zero during debug pause");
   min_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[pwmf_pkg::CTRL_MINPER] && ((|raw0) || (|raw1)) && (s.minper > pwmf_pkg::CNT_ONE))
      |=> ##1 (fault_act && s.isr[0]))
      else $error("minimum fault period not held");

   // ---------------------------------------------------------------
   // mode, update and fault checks
   // ---------------------------------------------------------------
   mode_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.mdirty && (msync == pwmf_pkg::PWMF_SYNC_IMM))
      |=> (s.aupdn == $past(s.ctrl[pwmf_pkg::CTRL_UPDOWN])))
      else $error("mode change not immediate");
   mode_local_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.mdirty && (msync == pwmf_pkg::PWMF_SYNC_LOCAL) && !at_zero)
      |=> (s.aupdn == $past(s.aupdn)))
      else $error("local mode change away from zero");
   mode_global_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.mdirty && (msync == pwmf_pkg::PWMF_SYNC_GLOBAL) && !s.glob)
      |=> (s.aupdn == $past(s.aupdn)))
      else $error("global mode change without request");
   db_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ddirty && (dsync == pwmf_pkg::PWMF_SYNC_IMM))
      |=> (s.adbr == $past(s.dbr)))
      else $error("dead-band change not immediate");
   db_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ddirty && (dsync != pwmf_pkg::PWMF_SYNC_IMM) && !at_zero)
      |=> (s.adbr == $past(s.adbr)))
      else $error("dead-band change away from zero");
   load_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.pdirty && at_zero && !s.ctrl[pwmf_pkg::CTRL_SYNCUPD])
      |=> (s.aload == $past(s.load)))
      else $error("free update did not apply at zero");
   debug_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (halt && s.ctrl[pwmf_pkg::CTRL_DBG_RUN] && s.en)
      |-> tick)
      else $error("counter stopped in debug run");
   latch_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[pwmf_pkg::CTRL_LATCHED] && !(wr_i && (addr_i == pwmf_pkg::REG_FSTAT0)))
      |=> ((s.stat0 & $past(s.stat0)) == $past(s.stat0)))
      else $error("latched trigger lost");
   group_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[pwmf_pkg::CTRL_LATCHED] && wr_i && (addr_i == pwmf_pkg::REG_FSTAT1) &&
       (raw1 == 8'h00))
      |=> (s.stat1 == ($past(s.stat1) & ~$past(wdata_i[7:0]))))
      else $error("group clear wrong");
   legacy_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !s.ctrl[pwmf_pkg::CTRL_EXTSRC]
      |-> ((raw0[3:1] == 3'h0) && (raw1 == 8'h00)))
      else $error("legacy mode used other triggers");
   sense_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[pwmf_pkg::CTRL_EXTSRC] && s.trig0[0])
      |-> (raw0[0] == (pins[0] == s.sense[0])))
      else $error("fault sense not applied");
   irq_or_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fault_now
      |=> s.isr[0])
      else $error("fault interrupt not raised");
   min_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[pwmf_pkg::CTRL_MINPER] && (s.minc != pwmf_pkg::CNT_ZERO) && !(|raw0) && !(|raw1))
      |=> (s.minc == $past(s.minc) - pwmf_pkg::CNT_ONE))
      else $error("minimum period not counted per clock");
   db_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.adben && !fault_act)
      |=> (s.generator_output_second == $past(db_out)))
      else $error("second output not from dead-band");
endmodule

// ---- test/pwm_generator_fault_control_tb.sv ----
// Purpose: self-checking bench for the pulse-width generator with fault control
// Assumes: one-cycle register strobes, read data in the cycle after the read strobe
// Notes: the counter is followed through back-to-back reads of the count register
`timescale 1ns/1ns
module pwm_generator_fault_control_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [3:0] pin = 4'h0;
   logic [7:0] dcmp = 8'h00;
   logic halt = 1'b0;
   logic generator_output_first;
   logic generator_output_second;
   logic irq;
   int failures = 0;
   int n_tests = 0;
   logic [15:0] l1;
   logic [15:0] l2;
   logic [15:0] l3;
   logic [31:0] v;
   logic [31:0] w;
   int j;
   int m;
   int r;
   int f;
   int dr;
   int df;

   always #20 clk_i = ~clk_i;

   pwmf_generator u_dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .addr_i(addr),
      .wdata_i(wdata),
      .wr_i(wr),
      .rd_i(rd),
      .rdata_o(rdata),
      .external_fault_input_i(pin),
      .dcmp_i(dcmp),
      .debug_halt_i(halt),
      .generator_output_first_o(generator_output_first),
      .generator_output_second_o(generator_output_second),
      .generator_zero_fault_irq_o(irq)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task results;
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask

   task rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(negedge clk_i);
      d = rdata;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // next count from the two previous ones
   function automatic logic [15:0] nxt(input logic [15:0] pp, input logic [15:0] p,
                                       input logic [15:0] ld, input logic ud);
      if (!ud) return (p == 16'h0000) ? ld : p - 16'h0001;
      if (p == 16'h0000) return 16'h0001;
      if (p == ld) return ld - 16'h0001;
      return p + p - pp;
   endfunction

   // reads the count every cycle and checks each read from the third on
   task samp(input int n, input logic [15:0] ld, input logic ud);
      logic [15:0] pp;
      logic [15:0] p;
      @(posedge clk_i);
      addr <= pwmf_pkg::REG_COUNT;
      rd <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         @(negedge clk_i);
         if (i >= 2) chk("count", rdata, {16'h0000, nxt(pp, p, ld, ud)});
         pp = p;
         p = rdata[15:0];
      end
      @(posedge clk_i);
      rd <= 1'b0;
   endtask

   // cycles from an edge of the first output to the same edge of the second
   task gap(input logic lv, output int d);
      int t;
      t = 0;
      d = 0;
      while (generator_output_first !== !lv && t < 300) begin @(negedge clk_i); t++; end
      while (generator_output_first !== lv && t < 300) begin @(negedge clk_i); t++; end
      while (generator_output_second !== lv && t < 300) begin @(negedge clk_i); t++; d++; end
      if (t >= 300) failures++;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      results();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      j = $urandom(32'h9d43);
      l1 = 16'h0004 + 16'($urandom % 12);
      l2 = 16'h0004 + 16'($urandom % 12);
      l3 = 16'h0028;
      cyc(6);
      rst_i <= 1'b0;
      rreg(pwmf_pkg::REG_CTRL, v);
      chk("ctrl", v, 32'h0);
      rreg(pwmf_pkg::REG_FSENSE, v);
      chk("fsense", v, 32'hF);
      rreg(8'hFC, v);
      chk("unmapped", v, 32'h0);
      wreg(pwmf_pkg::REG_LOAD, {16'h0000, l1});
      wreg(pwmf_pkg::REG_ENABLE, 32'h1);
      samp(3 * l1 + 6, l1, 1'b0);
      wreg(pwmf_pkg::REG_ENABLE, 32'h0);
      rreg(pwmf_pkg::REG_COUNT, v);
      cyc(5);
      rreg(pwmf_pkg::REG_COUNT, w);
      chk("stopped", w, v);
      wreg(pwmf_pkg::REG_ENABLE, 32'h1);
      wreg(pwmf_pkg::REG_LOAD, {16'h0000, l2});
      samp(2 * (l1 + l2) + 6, l2, 1'b0);
      // counting mode: immediate, global, local
      wreg(pwmf_pkg::REG_CTRL, 32'h1);
      rreg(pwmf_pkg::REG_ENABLE, v);
      chk("enable", v, 32'h0);
      wreg(pwmf_pkg::REG_ENABLE, 32'h1);
      samp(3 * l2 + 6, l2, 1'b1);
      wreg(pwmf_pkg::REG_CTRL, 32'h10);
      wreg(pwmf_pkg::REG_ENABLE, 32'h1);
      samp(3 * l2 + 6, l2, 1'b1);
      wreg(pwmf_pkg::REG_SYNC, 32'h1);
      cyc(2 * l2 + 4);
      samp(3 * l2 + 6, l2, 1'b0);
      wreg(pwmf_pkg::REG_CTRL, 32'h9);
      wreg(pwmf_pkg::REG_ENABLE, 32'h1);
      cyc(l2 + 4);
      samp(3 * l2 + 6, l2, 1'b1);
      // dead-band, immediate
      r = 1 + $urandom % 6;
      f = 1 + $urandom % 6;
      wreg(pwmf_pkg::REG_CTRL, 32'h400);
      wreg(pwmf_pkg::REG_LOAD, {16'h0000, l3});
      wreg(pwmf_pkg::REG_CMPA, 32'h14);
      wreg(pwmf_pkg::REG_DBRISE, r);
      wreg(pwmf_pkg::REG_DBFALL, f);
      wreg(pwmf_pkg::REG_ENABLE, 32'h1);
      gap(1'b1, dr); // settle past stale comparator
      gap(1'b1, dr);
      gap(1'b0, df);
      chk("deadband", dr - df, r - f);
      // synchronous update
      wreg(pwmf_pkg::REG_CTRL, 32'h2);
      wreg(pwmf_pkg::REG_ENABLE, 32'h1);
      wreg(pwmf_pkg::REG_LOAD, {16'h0000, l1});
      samp(2 * l3 + 6, l3, 1'b0);
      wreg(pwmf_pkg::REG_SYNC, 32'h1);
      cyc(l3 + 4);
      samp(3 * l1 + 6, l1, 1'b0);
      // debug halt
      wreg(pwmf_pkg::REG_CTRL, 32'h0);
      wreg(pwmf_pkg::REG_ENABLE, 32'h1);
      halt <= 1'b1;
      cyc(2 * l1 + 10);
      rreg(pwmf_pkg::REG_COUNT, v);
      cyc(5);
      rreg(pwmf_pkg::REG_COUNT, w);
      chk("paused", {v[15:0], w[15:0]}, 32'h0);
      wreg(pwmf_pkg::REG_CTRL, 32'h4);
      wreg(pwmf_pkg::REG_ENABLE, 32'h1);
      samp(3 * l1 + 6, l1, 1'b0);
      halt <= 1'b0;
      // legacy fault source
      wreg(pwmf_pkg::REG_CTRL, 32'h0);
      wreg(pwmf_pkg::REG_TRIG0, 32'hF);
      wreg(pwmf_pkg::REG_TRIG1, 32'hFF);
      pin <= 4'hE;
      dcmp <= 8'h01 + 8'($urandom % 255);
      cyc(8);
      chk("legacy", irq, 1'b0);
      pin <= 4'hF;
      cyc(8);
      chk("irq", irq, 1'b1);
      pin <= 4'hF;
      dcmp <= 8'h00;
      wreg(pwmf_pkg::REG_FSENSE, 32'hF);
      pin <= 4'h0;
      cyc(8);
      wreg(pwmf_pkg::REG_FISR, 32'h1);
      @(negedge clk_i);
      chk("irq clear", irq, 1'b0);
      // extended, low sense on one pin, unlatched
      j = $urandom % 4;
      cyc(1);
      pin <= 4'hF;
      wreg(pwmf_pkg::REG_CTRL, 32'h200);
      wreg(pwmf_pkg::REG_TRIG0, 32'h1 << j);
      wreg(pwmf_pkg::REG_TRIG1, 32'h0);
      wreg(pwmf_pkg::REG_FSENSE, 32'hF ^ (32'h1 << j));
      cyc(8);
      wreg(pwmf_pkg::REG_FISR, 32'h1);
      pin <= 4'hF ^ (4'h1 << j);
      cyc(8);
      rreg(pwmf_pkg::REG_FSTAT0, v);
      chk("fstat0", {v[30:0], irq}, (32'h1 << (j + 1)) | 32'h1);
      cyc(1);
      pin <= 4'hF;
      cyc(8);
      rreg(pwmf_pkg::REG_FSTAT0, v);
      chk("unlatched", v, 32'h0);
      // extended, latched comparator trigger
      m = $urandom % 8;
      wreg(pwmf_pkg::REG_CTRL, 32'h280);
      wreg(pwmf_pkg::REG_TRIG1, 32'h1 << m);
      dcmp <= 8'h01 << m;
      cyc(4);
      dcmp <= 8'h00;
      cyc(8);
      rreg(pwmf_pkg::REG_FSTAT1, v);
      chk("latched", v, 32'h1 << m);
      wreg(pwmf_pkg::REG_FSTAT1, 32'h1 << m);
      rreg(pwmf_pkg::REG_FSTAT1, v);
      chk("group clear", v, 32'h0);
      // minimum fault period
      wreg(pwmf_pkg::REG_CTRL, 32'h300);
      wreg(pwmf_pkg::REG_MINPER, 32'h1E);
      wreg(pwmf_pkg::REG_FISR, 32'h1);
      dcmp <= 8'h01 << m;
      @(posedge clk_i);
      dcmp <= 8'h00;
      cyc(6);
      wreg(pwmf_pkg::REG_FISR, 32'h1);
      @(negedge clk_i);
      chk("min period", irq, 1'b1);
      cyc(40);
      wreg(pwmf_pkg::REG_FISR, 32'h1);
      @(negedge clk_i);
      chk("period over", irq, 1'b0);
      results();
   end
endmodule
